// File: adrp_master.sv
/*
  master model for the serial port: select, mode 1 shift, release.
  assumes the core clock paces it; the bench resolves the shared line.
*/
`timescale 1ns/100ps
module adrp_master (
  // pacing and shared line
  input wire logic i_core_clk,
  input wire logic i_line,
  // pins toward the port
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din
);
  logic [15:0] word = 16'h0000;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din = 1'b0;
  end
  // ==========================================
  // pin sequencing
  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  // each device has its own select; lowering it polls the ready level
  task automatic select(output logic rdy);
    step(1);
    o_cs_n = 1'b0;
    word = 16'h0000;
    step(6);
    rdy = i_line;
  endtask
  // gap stretches the low phase after bit 8, only to provoke an abandon
  task automatic shift(input logic [15:0] cfg, input int nbits, input int gap);
    for (int i = 0; i < nbits; i++) begin
      o_sclk = 1'b1;
      o_din = cfg[15-i];
      step(8);
      o_sclk = 1'b0;
      word = {word[14:0], i_line};
      step(i == 7 ? 8 + gap : 8);
    end
  endtask
  task automatic deselect();
    step(1);
    o_cs_n = 1'b1;
    step(6);
  endtask
endmodule

// File: adrp_pkg.sv
/*
  constants for the data-ready serial port of a small sensor converter.
  assumes one core clock of 25 MHz; serial pins arrive asynchronously.
*/
// Function
// - while deselected and pull-up enabled, output line is weakly pulled high.
// - pull-up enable cleared: line goes high impedance when select rises.
// - no data-ready indication is ever driven while select is high.
// - on select falling, line is driven at once, high or low by data status.
// - driven low after select means a fresh result is ready to shift out.
// - no fresh result: drive high and shift out last read result again.
// - result completing mid-transfer does not alter shifted word; readable next transfer.
// - master may read a valid uncorrupted result at any moment.
// - single-ended selection converts chosen channel against ground, returns its result.
// - mux offers inputs 0, 1 and 2 each against input 3 as common point.
// - mode 1: clock idles low, launch on rising, sample on falling edges.
// - clock held low longer than the timeout abandons the transfer; the port only times out once at least one bit has been sampled (bits != 0).
package adrp_pkg;
  // ==========================================
  // word layout
  localparam int DATA_W = 16;
  localparam int CFG_W = 16;
  localparam int MUX_LSB = 12;
  localparam int MUX_W = 3;
  localparam int PULLUP_BIT = 3;
  localparam logic [CFG_W-1:0] CFG_RESET = 16'h058b;
  // ==========================================
  // mux selections
  localparam logic [MUX_W-1:0] MUX_0_3 = 3'h1;
  localparam logic [MUX_W-1:0] MUX_1_3 = 3'h2;
  localparam logic [MUX_W-1:0] MUX_2_3 = 3'h3;
  localparam logic [MUX_W-1:0] MUX_SE0 = 3'h4;
  localparam logic [MUX_W-1:0] MUX_SE3 = 3'h7;
  // ==========================================
  // timing
  localparam int CLK_HZ = 25000000;
  localparam int TIMEOUT_MS = 28;
  localparam int TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [1:0] {ADRP_IDLE, ADRP_SHIFT, ADRP_ABORT} adrp_state_t;
endpackage

// File: adrp_port.sv
/*
  serial data-ready port and result fifo.
  assumes the converter core delivers results with valid/ready and the
  pad resolves output, enable and weak pull-up request.
*/
`timescale 1ns/100ps
// ==========================================
// result fifo
module adrp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic push, pop;
  always_comb begin
    push = i_valid && o_ready;
    pop = o_valid && i_ready;
    next_wr_ptr = wr_ptr + (AW+1)'(push);
    next_rd_ptr = rd_ptr + (AW+1)'(pop);
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      o_ready <= 1'b0;
      o_valid <= 1'b0;
      o_data <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      o_ready <= (next_wr_ptr - next_rd_ptr) != (AW+1)'(DEPTH);
      o_valid <= (next_wr_ptr - next_rd_ptr) != '0;
      o_data <= mem[next_rd_ptr[AW-1:0]];
      if (push) begin
        mem[wr_ptr[AW-1:0]] <= i_data;
        if (next_rd_ptr[AW-1:0] == wr_ptr[AW-1:0]) o_data <= i_data;
      end
    end
  end
endmodule

// ==========================================
// serial port
module adrp_port
  import adrp_pkg::*;
#(
  parameter int TIMEOUT = TIMEOUT_CYC
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // serial pins
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  output logic o_data_out_ready_line,
  output logic o_data_out_ready_line_oe,
  output logic o_data_out_ready_line_pullup,
  // converter side
  input wire logic i_result_valid,
  output logic o_result_ready,
  input wire logic [adrp_pkg::DATA_W-1:0] i_result,
  // configuration to converter
  output logic [adrp_pkg::MUX_W-1:0] o_mux_sel,
  output logic o_mux_se,
  output logic o_mux_common3
);
  import adrp_pkg::*;
  initial begin
    if (TIMEOUT < 2) $error("timeout too small");
  end
  // ==========================================
  // synchronisers
  logic [2:0] sclk_s, cs_s;
  logic [1:0] din_s;
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      sclk_s <= 3'h0;
      cs_s <= 3'h7;
      din_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], i_sclk};
      cs_s <= {cs_s[1:0], i_cs_n};
      din_s <= {din_s[0], i_din};
    end
  end
  logic sclk_rise, sclk_fall, cs_fall, cs_rise, cs_hi;
  always_comb begin
    sclk_rise = sclk_s[1] && !sclk_s[2];
    sclk_fall = !sclk_s[1] && sclk_s[2];
    cs_fall = !cs_s[1] && cs_s[2];
    cs_rise = cs_s[1] && !cs_s[2];
    cs_hi = cs_s[1];
  end
  // ==========================================
  // fifo between converter and port
  logic f_valid, f_pop;
  logic [DATA_W-1:0] f_data;
  adrp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_valid(i_result_valid),
    .o_ready(o_result_ready),
    .i_data(i_result),
    .o_valid(f_valid),
    .i_ready(f_pop),
    .o_data(f_data)
  );
  // ==========================================
  // transfer state
  adrp_state_t state, next_state;
  logic [DATA_W-1:0] latest, next_latest, shreg, next_shreg;
  logic [CFG_W-1:0] cfg, next_cfg, inreg, next_inreg;
  logic [4:0] bits, next_bits;
  logic fresh, next_fresh, dout, next_dout, oe, next_oe, pu, next_pu;
  logic [$clog2(TIMEOUT+1)-1:0] lowcnt, next_lowcnt;
  always_comb begin
    next_state = state;
    next_latest = latest;
    next_shreg = shreg;
    next_cfg = cfg;
    next_inreg = inreg;
    next_bits = bits;
    next_fresh = fresh;
    next_dout = dout;
    next_oe = oe;
    next_pu = pu;
    next_lowcnt = lowcnt;
    // latest result stays frozen while shifting; fifo drains in idle and in abort, never in shift
    f_pop = f_valid && (state != ADRP_SHIFT) && !cs_fall;
    if (f_pop) begin
      next_latest = f_data;
      next_fresh = 1'b1;
    end
    unique case (state)
      ADRP_IDLE: begin
        if (cs_fall) begin
          // snapshot taken at selection so a late result never tears the word
          next_shreg = latest;
          next_dout = !fresh;
          next_oe = 1'b1;
          next_bits = 5'h0;
          next_lowcnt = '0;
          next_state = ADRP_SHIFT;
        end
      end
      ADRP_SHIFT: begin
        if (cs_hi) begin
          next_state = ADRP_IDLE;
        end else begin
          if (sclk_rise) begin
            if (bits == 5'h0) next_fresh = 1'b0;
            next_dout = shreg[DATA_W-1];
            next_shreg = {shreg[DATA_W-2:0], shreg[DATA_W-1]};
          end
          if (sclk_fall && bits < 5'(CFG_W)) begin
            next_inreg = {inreg[CFG_W-2:0], din_s[1]};
            next_bits = bits + 5'h1;
            if (bits == 5'(CFG_W-1)) next_cfg = {inreg[CFG_W-2:0], din_s[1]};
          end
          next_lowcnt = sclk_s[1] ? '0 : lowcnt + 1'b1;
          if (bits != 5'h0 && lowcnt == ($bits(lowcnt))'(TIMEOUT)) begin
            next_state = ADRP_ABORT;
          end
        end
      end
      ADRP_ABORT: begin
        if (cs_hi) next_state = ADRP_IDLE;
      end
    endcase
    if (cs_rise || cs_hi) begin
      next_oe = 1'b0;
      next_pu = next_cfg[PULLUP_BIT];
    end else if (cs_fall) begin
      next_pu = 1'b0;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      state <= ADRP_IDLE;
      latest <= '0;
      shreg <= '0;
      cfg <= CFG_RESET;
      inreg <= '0;
      bits <= '0;
      fresh <= 1'b0;
      dout <= 1'b1;
      oe <= 1'b0;
      pu <= 1'b1;
      lowcnt <= '0;
    end else begin
      state <= next_state;
      latest <= next_latest;
      shreg <= next_shreg;
      cfg <= next_cfg;
      inreg <= next_inreg;
      bits <= next_bits;
      fresh <= next_fresh;
      dout <= next_dout;
      oe <= next_oe;
      pu <= next_pu;
      lowcnt <= next_lowcnt;
    end
  end
  // ==========================================
  // outputs and mux decode
  logic [MUX_W-1:0] msel;
  always_comb msel = cfg[MUX_LSB +: MUX_W];
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_mux_sel <= '0;
      o_mux_se <= 1'b0;
      o_mux_common3 <= 1'b0;
    end else begin
      o_mux_sel <= msel;
      o_mux_se <= msel >= MUX_SE0 && msel <= MUX_SE3;
      o_mux_common3 <= msel >= MUX_0_3 && msel <= MUX_2_3;
    end
  end
  always_comb begin
    o_data_out_ready_line = dout;
    o_data_out_ready_line_oe = oe;
    o_data_out_ready_line_pullup = pu;
  end
  // ==========================================
  // checks
  no_drive_hi_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    cs_s[2] && cs_s[1] |=> !o_data_out_ready_line_oe) else $error("line driven while deselected");
  drive_on_sel_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    cs_fall && state == ADRP_IDLE |=> o_data_out_ready_line_oe) else $error("line not driven on select");
  ready_level_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    cs_fall && state == ADRP_IDLE |=> o_data_out_ready_line == !$past(fresh)) else $error("ready level wrong");
  frozen_word_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    state == ADRP_SHIFT |=> $stable(latest)) else $error("result changed in transfer");
  pullup_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    cs_rise |=> o_data_out_ready_line_pullup == cfg[PULLUP_BIT]) else $error("pull-up wrong");
  fresh_set_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    f_pop |=> fresh) else $error("fresh flag not set");
  mux_se_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    msel == MUX_SE0 |=> o_mux_se && !o_mux_common3) else $error("mux decode wrong");
  timeout_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    state == ADRP_SHIFT && !cs_hi && bits != 5'h0 && lowcnt == ($bits(lowcnt))'(TIMEOUT) |=> state == ADRP_ABORT)
    else $error("timeout missed");
  sel_c: cover property (@(posedge i_core_clk) cs_fall && fresh);
  stale_c: cover property (@(posedge i_core_clk) cs_fall && !fresh);
  abort_c: cover property (@(posedge i_core_clk) state == ADRP_ABORT);
endmodule

// File: tb_top.sv
/*
  self-checking bench for the data-ready port and its result fifo.
  assumes adrp_master drives the pins; the pad is resolved here.
*/
`timescale 1ns/100ps
module tb_top;
  import adrp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rv = 1'b0;
  logic [DATA_W-1:0] res = 16'h0000;
  logic last_v = 1'b0;
  logic sclk, cs_n, din, dq, oe, pu, rr, se, c3, r;
  logic [MUX_W-1:0] mux;
  int n_fail = 0;
  int checked = 0;
  // released line without pull-up flips, so a held level cannot pass
  wire line = oe ? dq : (pu ? 1'b1 : ~last_v);
  always @(posedge clk) if (oe === 1'b1) last_v <= dq;
  initial forever #20 clk = ~clk;
  adrp_port #(.TIMEOUT(50)) adrp_port_inst (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
    .o_data_out_ready_line(dq), .o_data_out_ready_line_oe(oe), .o_data_out_ready_line_pullup(pu),
    .i_result_valid(rv), .o_result_ready(rr), .i_result(res),
    .o_mux_sel(mux), .o_mux_se(se), .o_mux_common3(c3));
  adrp_master adrp_master_inst (.i_core_clk(clk), .i_line(line), .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
  // ==========================================
  // helpers
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [15:0] cfgw(input logic [2:0] m, input logic p);
    return {1'b0, m, 8'h58, p, 3'h3};
  endfunction
  task automatic push(input logic [15:0] v);
    int n = 0;
    step(1);
    rv = 1'b1;
    res = v;
    while (rr !== 1'b1 && n < 200) begin
      step(1);
      n++;
    end
    chk_bit("result ready", 1'b1, rr);
    step(1);
    rv = 1'b0;
  endtask
  task automatic xfer(input logic [15:0] cfg, input logic erdy, input logic [15:0] ew);
    adrp_master_inst.select(r);
    chk_bit("ready level", erdy, r);
    chk_bit("line driven", 1'b1, oe);
    adrp_master_inst.shift(cfg, 16, 0);
    adrp_master_inst.deselect();
    chk_word("read word", ew, adrp_master_inst.word);
  endtask
  // ==========================================
  // scenarios
  task automatic t_fresh();
    push(16'ha5c3);
    step(4);
    xfer(cfgw(MUX_SE0, 1'b1), 1'b0, 16'ha5c3);
    chk_bit("single-ended", 1'b1, se);
    xfer(cfgw(MUX_SE3, 1'b1), 1'b1, 16'ha5c3);
    $display("test fresh and stale done");
  endtask
  task automatic t_mid();
    adrp_master_inst.select(r);
    adrp_master_inst.shift(cfgw(MUX_SE3, 1'b1), 8, 0);
    push(16'h3c96);
    adrp_master_inst.shift(cfgw(MUX_SE3, 1'b1) << 8, 8, 0);
    adrp_master_inst.deselect();
    chk_word("word in flight", 16'ha5c3, adrp_master_inst.word);
    xfer(cfgw(MUX_SE3, 1'b1), 1'b0, 16'h3c96);
    $display("test mid-transfer done");
  endtask
  task automatic t_mux();
    for (int c = 1; c < 8; c++) begin
      xfer(cfgw(3'(c), c[0]), 1'b1, 16'h3c96);
      chk_word("mux select", 16'(c), 16'(mux));
      chk_bit("common point", c < 4, c3);
      chk_bit("single-ended", c > 3, se);
      chk_bit("pull-up request", c[0], pu);
      chk_bit("released", 1'b0, oe);
    end
    $display("test mux done");
  endtask
  task automatic t_abandon();
    adrp_master_inst.select(r);
    adrp_master_inst.shift(cfgw(MUX_0_3, 1'b1), 16, 60);
    adrp_master_inst.deselect();
    chk_word("mux after abandon", 16'(MUX_SE3), 16'(mux));
    $display("test abandon done");
  endtask
  // the master stalls with select low while the fifo fills
  // once deselected the fifo drains in idle, so only the newest result is read
  task automatic t_fill();
    adrp_master_inst.select(r);
    chk_bit("poll no data", 1'b1, r);
    for (int i = 0; i < FIFO_DEPTH; i++) push(16'h8000 | 16'(i));
    step(2);
    chk_bit("fifo full", 1'b0, rr);
    chk_bit("ready held", 1'b1, line);
    adrp_master_inst.deselect();
    step(FIFO_DEPTH + 2);
    chk_bit("fifo drained", 1'b1, rr);
    for (int i = 0; i < FIFO_DEPTH; i++) xfer(cfgw(MUX_SE3, 1'b1), i != 0, 16'h8007);
    xfer(cfgw(MUX_SE3, 1'b1), 1'b1, 16'h8007);
    $display("test fill done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================
  // sequence and watchdog
  initial begin
    step(10);
    rst_n = 1'b1;
    step(4);
    chk_bit("select off drive", 1'b0, oe);
    chk_bit("idle line", 1'b1, line);
    chk_word("mux at reset", 16'h0000, 16'(mux));
    chk_bit("no common point", 1'b0, c3);
    t_fresh();
    t_mid();
    t_mux();
    t_abandon();
    t_fill();
    report_and_stop();
  end
  initial begin
    #(40 * 20000);
    n_fail++;
    report_and_stop();
  end
endmodule
